// ### design/ogrd_top.sv
`timescale 1ns/1ps
module ogrd_top #(
  parameter int BKPT_N = 4
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic reset_n,
  // test port, input pins asynchronous to sys_clk, tp_rdata registered on sys_clk
  input wire logic tp_tck,
  input wire ogrd_pkg::ogrd_tp_req_t tp_req,
  output logic [31:0] tp_rdata,
  // cpu register-move port and mode, on sys_clk
  input wire logic cpu_dr_valid,
  input wire logic cpu_dr_wr,
  input wire logic [4:0] cpu_dr_idx,
  input wire logic [31:0] cpu_dr_wdata,
  input wire ogrd_pkg::ogrd_cpu_mode_t cpu_mode,
  output logic [31:0] cpu_dr_rdata,
  // cpu control and feature gating
  output logic wake_req,
  output logic debug_exc_tag,
  output logic prog_trace_on,
  output logic data_trace_on,
  output logic mem_trace_on,
  output logic bkpt_allow,
  output logic watch_allow,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // interrupt
  output logic irq
);
  import ogrd_pkg::*;

  //============================================================================
  // elaboration checks
  initial
  begin
    if (BKPT_N < 1 || BKPT_N > 16)
    begin
      $error("ogrd_top: BKPT_N must lie in 1..16");
    end
  end

  //============================================================================
  // test port synchroniser
  ogrd_tp_req_t req_s1_r; // first stage, read only by the second
  ogrd_tp_req_t req_s2_r;
  logic tck_s1_r;
  logic tck_s2_r;
  logic tck_s3_r; // previous synchronised level, for edge finding
  logic tck_rise;

  // two flops on every pin before any logic looks at it
  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      req_s1_r <= '0;
      req_s2_r <= '0;
      tck_s1_r <= 1'b0;
      tck_s2_r <= 1'b0;
      tck_s3_r <= 1'b0;
    end
    else
    begin
      req_s1_r <= tp_req;
      req_s2_r <= req_s1_r;
      tck_s1_r <= tp_tck;
      tck_s2_r <= tck_s1_r;
      tck_s3_r <= tck_s2_r;
    end
  end

  // debugger changes pins away from the rising edge, so the synced
  // request is settled when the synced tck edge shows up
  assign tck_rise = tck_s2_r && !tck_s3_r;

  //============================================================================
  // debug register file and derived state
  logic [31:0] dreg_r [OGRD_NREG];
  logic stop_flag_r;
  logic ocd_en;
  logic ocd_halted; // halted in ocd mode, not monitor
  logic in_monitor;
  logic pc_bkpt_on;
  logic dat_bkpt_on;
  logic [TRACE_CH_N-1:0] trace_ch_on;
  logic [DC_ORP_W-1:0] orp_deny;
  logic [31:0] bkpt_en_mask;
  logic [31:0] chan_mask;
  logic dbg_q_r; // cpu debug mode, previous cycle
  logic dbg_entry;
  logic dbg_exit;

  assign ocd_en = dreg_r[IDX_DEBUG_CONTROL][DC_EN_BIT];
  assign ocd_halted = cpu_mode.debug_mode && !cpu_mode.monitor;
  assign in_monitor = cpu_mode.debug_mode && cpu_mode.monitor;
  assign pc_bkpt_on = |dreg_r[IDX_BKPT_CTRL_PC][BKPT_N-1:0];
  assign dat_bkpt_on = |dreg_r[IDX_BKPT_CTRL_DATA][BKPT_N-1:0];
  assign trace_ch_on = dreg_r[IDX_DATA_TRACE_CTRL][TRACE_CH_N-1:0];
  assign orp_deny = dreg_r[IDX_DEBUG_CONTROL][DC_ORP_LSB +: DC_ORP_W];
  assign bkpt_en_mask = MASK_ALL >> (32 - BKPT_N);
  assign chan_mask = MASK_ALL >> (32 - TRACE_CH_N);
  assign dbg_entry = cpu_mode.debug_mode && !dbg_q_r;
  assign dbg_exit = !cpu_mode.debug_mode && dbg_q_r;

  // mode edge history
  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
      dbg_q_r <= 1'b0;
    else
      dbg_q_r <= cpu_mode.debug_mode;
  end

  //============================================================================
  // test port write permission, as a per-bit mask
  logic [31:0] tp_mask;
  logic tp_we;

  always_comb
  begin
    tp_mask = MASK_NONE;
    if (!ocd_en || ocd_halted)
    begin
      // unrestricted, only the status word is hardware-owned
      tp_mask = (req_s2_r.idx == IDX_DEV_STATUS) ? MASK_NONE : MASK_ALL;
    end
    else
    begin
      unique case (req_s2_r.idx)
        // plain runtime-writable registers
        IDX_DEBUG_CONTROL, IDX_MEM_ACC_CTRL, IDX_MEM_ACC_ADDR, IDX_MEM_ACC_DATA,
        IDX_WATCH_TRIGGER, IDX_PROCESS_IDENT, IDX_COMM_CPU_SIDE,
        IDX_COMM_DEBUGGER_SIDE: tp_mask = MASK_ALL;
        // only channel enables change at runtime; start/end words only while their channel is off
        IDX_DATA_TRACE_CTRL: tp_mask = chan_mask;
        IDX_TRACE_START0, IDX_TRACE_END0: tp_mask = trace_ch_on[0] ? MASK_NONE : MASK_ALL;
        IDX_TRACE_START1, IDX_TRACE_END1: tp_mask = trace_ch_on[1] ? MASK_NONE : MASK_ALL;
        // enable bits only
        IDX_BKPT_CTRL_PC, IDX_BKPT_CTRL_DATA: tp_mask = bkpt_en_mask;
        // only while the related breakpoint is off
        IDX_BKPT_ADDR_PC: tp_mask = pc_bkpt_on ? MASK_NONE : MASK_ALL;
        IDX_BKPT_ADDR_DATA, IDX_BKPT_DATA: tp_mask = dat_bkpt_on ? MASK_NONE : MASK_ALL;
        IDX_EVENT_PAIR: tp_mask = (pc_bkpt_on || dat_bkpt_on) ? MASK_NONE : MASK_ALL;
        // never at runtime
        IDX_DEBUG_TUNING, IDX_DEBUG_INSTR, IDX_DEBUG_PC: tp_mask = MASK_NONE;
        default: tp_mask = MASK_NONE;
      endcase
    end
  end

  // a masked-out write still "happens" but changes nothing
  assign tp_we = tck_rise && req_s2_r.sel && req_s2_r.wr;

  //============================================================================
  // cpu write permission
  logic [31:0] cpu_mask;
  logic cpu_priv;
  logic cpu_allowed;
  logic cpu_we;
  logic [2:0] orp_sel;

  assign cpu_priv = cpu_mode.priv != 3'h0;
  assign orp_sel = cpu_mode.priv - 3'h1;
  assign cpu_allowed = cpu_priv && !orp_deny[orp_sel];

  always_comb
  begin
    cpu_mask = MASK_NONE;
    if (!cpu_priv)
      cpu_mask = MASK_NONE; // unprivileged code owns nothing here
    else if (!cpu_allowed)
    begin
      // protect setting denies this mode
      if (cpu_dr_idx == IDX_PROCESS_IDENT || cpu_dr_idx == IDX_COMM_CPU_SIDE)
        cpu_mask = MASK_ALL;
    end
    else if (ocd_halted)
      // moves also serve the debugger while halted
      cpu_mask = (cpu_dr_idx == IDX_DEV_STATUS) ? MASK_NONE : MASK_ALL;
    else
    begin
      unique case (cpu_dr_idx)
        IDX_DEBUG_CONTROL, IDX_WATCH_TRIGGER, IDX_PROCESS_IDENT,
        IDX_COMM_CPU_SIDE, IDX_COMM_DEBUGGER_SIDE: cpu_mask = MASK_ALL;
        IDX_DATA_TRACE_CTRL, IDX_TRACE_START0, IDX_TRACE_START1,
        IDX_TRACE_END0, IDX_TRACE_END1: cpu_mask = MASK_ALL;
        IDX_MEM_ACC_CTRL, IDX_MEM_ACC_ADDR, IDX_MEM_ACC_DATA: cpu_mask = MASK_NONE;
        IDX_BKPT_CTRL_PC, IDX_BKPT_CTRL_DATA: cpu_mask = cpu_mode.debug_mask_flag ? MASK_ALL : MASK_NONE;
        IDX_BKPT_ADDR_PC: cpu_mask = (cpu_mode.debug_mask_flag || !pc_bkpt_on) ? MASK_ALL : MASK_NONE;
        IDX_BKPT_ADDR_DATA, IDX_BKPT_DATA:
          cpu_mask = (cpu_mode.debug_mask_flag || !dat_bkpt_on) ? MASK_ALL : MASK_NONE;
        IDX_EVENT_PAIR:
          cpu_mask = (cpu_mode.debug_mask_flag || !(pc_bkpt_on || dat_bkpt_on)) ? MASK_ALL : MASK_NONE;
        IDX_DEBUG_TUNING, IDX_DEBUG_INSTR, IDX_DEBUG_PC: cpu_mask = MASK_NONE;
        default: cpu_mask = MASK_NONE;
      endcase
    end
  end

  assign cpu_we = cpu_dr_valid && cpu_dr_wr;

  //============================================================================
  // register entries; test port wins a same-cycle clash on one index
  genvar gi;
  generate
    for (gi = 0; gi < OGRD_NREG; gi++)
    begin : g_entry
      localparam logic [4:0] MY_IDX = 5'(gi);
      // merge only the permitted bits, the rest stay as they were
      always_ff @(posedge sys_clk or negedge reset_n)
      begin
        if (!reset_n)
          dreg_r[gi] <= RESET_WORD;
        else if (tp_we && req_s2_r.idx == MY_IDX)
          dreg_r[gi] <= (dreg_r[gi] & ~tp_mask) | (req_s2_r.wdata & tp_mask);
        else if (cpu_we && cpu_dr_idx == MY_IDX)
          dreg_r[gi] <= (dreg_r[gi] & ~cpu_mask) | (cpu_dr_wdata & cpu_mask);
        else if (MY_IDX == IDX_DEBUG_CONTROL && dbg_entry)
          // the request is consumed once debug mode is reached
          dreg_r[gi][DC_REQ_BIT] <= 1'b0;
      end
    end
  endgenerate

  //============================================================================
  // reads: any time from the port, privileged only from the cpu
  logic [31:0] tp_word;
  logic [31:0] cpu_word;

  always_comb
  begin
    tp_word = MASK_NONE;
    cpu_word = MASK_NONE;
    if (req_s2_r.idx == IDX_DEV_STATUS)
      tp_word[DS_STOP_BIT] = stop_flag_r;
    else if (req_s2_r.idx < OGRD_NREG[4:0])
      tp_word = dreg_r[req_s2_r.idx];
    if (cpu_dr_idx == IDX_DEV_STATUS)
      cpu_word[DS_STOP_BIT] = stop_flag_r;
    else if (cpu_dr_idx < OGRD_NREG[4:0])
      cpu_word = dreg_r[cpu_dr_idx];
  end

  // read data registers
  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      tp_rdata <= RESET_WORD;
      cpu_dr_rdata <= RESET_WORD;
    end
    else
    begin
      if (tck_rise && req_s2_r.sel && !req_s2_r.wr)
        tp_rdata <= tp_word;
      if (cpu_dr_valid && !cpu_dr_wr && cpu_priv)
        cpu_dr_rdata <= cpu_word;
    end
  end

  //============================================================================
  // sleep wake-up sequence
  ogrd_wake_t wk_r;
  logic wk_start;

  assign wk_start = (wk_r == WK_IDLE) && cpu_mode.sleeping &&
                    dreg_r[IDX_DEBUG_CONTROL][DC_REQ_BIT];

  // wake the cpu, then hold the tag until debug mode is reached
  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
      wk_r <= WK_IDLE;
    else
    begin
      unique case (wk_r)
        WK_IDLE: if (wk_start) wk_r <= WK_WAKE;
        WK_WAKE: if (!cpu_mode.sleeping) wk_r <= WK_TAG;
        WK_TAG: if (cpu_mode.debug_mode) wk_r <= WK_IDLE;
        default: wk_r <= WK_IDLE;
      endcase
    end
  end

  // stop flag: set on sleep-sourced entry, cleared on leaving; set wins
  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
      stop_flag_r <= 1'b0;
    else if (wk_r == WK_TAG && cpu_mode.debug_mode)
      stop_flag_r <= 1'b1;
    else if (dbg_exit)
      // the cpu resumes past sleep unless the return address is moved back
      stop_flag_r <= 1'b0;
  end

  //============================================================================
  // cpu-facing control outputs
  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      wake_req <= 1'b0;
      debug_exc_tag <= 1'b0;
      prog_trace_on <= 1'b0;
      data_trace_on <= 1'b0;
      mem_trace_on <= 1'b0;
      bkpt_allow <= 1'b0;
      watch_allow <= 1'b0;
    end
    else
    begin
      wake_req <= (wk_r == WK_WAKE) || wk_start;
      debug_exc_tag <= (wk_r == WK_TAG) && !cpu_mode.debug_mode;
      // trace is muted while in debug mode
      prog_trace_on <= ocd_en && dreg_r[IDX_DEBUG_CONTROL][DC_PTRACE_BIT] &&
                       !cpu_mode.debug_mode;
      data_trace_on <= ocd_en && dreg_r[IDX_DEBUG_CONTROL][DC_DTRACE_BIT] &&
                       (|trace_ch_on) && !cpu_mode.debug_mode;
      mem_trace_on <= ocd_en && dreg_r[IDX_DEBUG_CONTROL][DC_MTRACE_BIT] &&
                      !cpu_mode.debug_mode;
      bkpt_allow <= !cpu_mode.debug_mode || (in_monitor && !cpu_mode.debug_mask_flag);
      watch_allow <= !cpu_mode.debug_mode || in_monitor;
    end
  end

  //============================================================================
  // interrupt status, enable and output
  logic [IRQ_N-1:0] irq_stat_r;
  logic [IRQ_N-1:0] irq_en_r;
  logic [IRQ_N-1:0] irq_evt;
  logic [IRQ_N-1:0] irq_clr;
  logic apb_wr_done;

  assign apb_wr_done = psel && penable && pready && pwrite;
  assign irq_clr = (apb_wr_done && paddr == APB_IRQ_CLEAR) ? pwdata[IRQ_N-1:0] : '0;
  assign irq_evt[IRQ_WAKE] = wk_start;
  assign irq_evt[IRQ_SLEEP_ENTRY] = (wk_r == WK_TAG) && cpu_mode.debug_mode;
  assign irq_evt[IRQ_PORT_WRITE] = tp_we && (tp_mask != MASK_NONE);

  // sticky bits; a new event beats a clear in the same cycle
  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      irq_stat_r <= '0;
      irq_en_r <= '0;
      irq <= 1'b0;
    end
    else
    begin
      irq_stat_r <= (irq_stat_r & ~irq_clr) | irq_evt;
      if (apb_wr_done && paddr == APB_IRQ_ENABLE)
        irq_en_r <= pwdata[IRQ_N-1:0];
      irq <= |(((irq_stat_r & ~irq_clr) | irq_evt) & irq_en_r);
    end
  end

  //============================================================================
  // apb slave: one wait state, answer on the second access cycle
  logic apb_hit;
  logic [31:0] apb_word;

  always_comb
  begin
    apb_hit = 1'b1;
    apb_word = MASK_NONE;
    unique case (paddr)
      APB_IRQ_STATUS: apb_word[IRQ_N-1:0] = irq_stat_r;
      APB_IRQ_CLEAR: apb_word = MASK_NONE; // write-only, reads zero
      APB_IRQ_ENABLE: apb_word[IRQ_N-1:0] = irq_en_r;
      APB_MODE_VIEW: apb_word[9:0] = {stop_flag_r, wk_r, cpu_mode};
      default: apb_hit = 1'b0;
    endcase
  end

  // pready pulses for one cycle; prdata holds until the next read
  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= RESET_WORD;
    end
    else
    begin
      pready <= psel && penable && !pready;
      pslverr <= psel && penable && !pready && !apb_hit;
      if (psel && penable && !pready && !pwrite)
        prdata <= apb_word;
    end
  end

endmodule : ogrd_top

// ### design/ogrd_pkg.sv
//==============================================================================
//==============================================================================
package ogrd_pkg;

  //============================================================================
  // debug register indices
  localparam int OGRD_NREG = 23;
  localparam int OGRD_IDXW = 5;
  localparam logic [4:0] IDX_DEBUG_CONTROL = 5'h00;
  localparam logic [4:0] IDX_MEM_ACC_CTRL = 5'h01;
  localparam logic [4:0] IDX_MEM_ACC_ADDR = 5'h02;
  localparam logic [4:0] IDX_MEM_ACC_DATA = 5'h03;
  localparam logic [4:0] IDX_WATCH_TRIGGER = 5'h04;
  localparam logic [4:0] IDX_DATA_TRACE_CTRL = 5'h05;
  localparam logic [4:0] IDX_TRACE_START0 = 5'h06;
  localparam logic [4:0] IDX_TRACE_START1 = 5'h07;
  localparam logic [4:0] IDX_TRACE_END0 = 5'h08;
  localparam logic [4:0] IDX_TRACE_END1 = 5'h09;
  localparam logic [4:0] IDX_BKPT_CTRL_PC = 5'h0a;
  localparam logic [4:0] IDX_BKPT_CTRL_DATA = 5'h0b;
  localparam logic [4:0] IDX_BKPT_ADDR_PC = 5'h0c;
  localparam logic [4:0] IDX_BKPT_ADDR_DATA = 5'h0d;
  localparam logic [4:0] IDX_BKPT_DATA = 5'h0e;
  localparam logic [4:0] IDX_PROCESS_IDENT = 5'h0f;
  localparam logic [4:0] IDX_DEBUG_TUNING = 5'h10;
  localparam logic [4:0] IDX_EVENT_PAIR = 5'h11;
  localparam logic [4:0] IDX_DEBUG_INSTR = 5'h12;
  localparam logic [4:0] IDX_DEBUG_PC = 5'h13;
  localparam logic [4:0] IDX_COMM_CPU_SIDE = 5'h14;
  localparam logic [4:0] IDX_COMM_DEBUGGER_SIDE = 5'h15;
  localparam logic [4:0] IDX_DEV_STATUS = 5'h16;

  //============================================================================
  // field positions
  localparam int DC_REQ_BIT = 0;
  localparam int DC_EN_BIT = 1;
  localparam int DC_ORP_LSB = 2;
  localparam int DC_ORP_W = 7;
  localparam int DC_PTRACE_BIT = 9;
  localparam int DC_DTRACE_BIT = 10;
  localparam int DC_MTRACE_BIT = 11;
  localparam int DS_STOP_BIT = 0;
  localparam int TRACE_CH_N = 2;
  localparam logic [31:0] MASK_ALL = 32'hffffffff;
  localparam logic [31:0] MASK_NONE = 32'h00000000;
  localparam logic [31:0] RESET_WORD = 32'h00000000;

  //============================================================================
  // apb map of the block's own registers
  localparam logic [11:0] APB_IRQ_STATUS = 12'h000;
  localparam logic [11:0] APB_IRQ_CLEAR = 12'h004;
  localparam logic [11:0] APB_IRQ_ENABLE = 12'h008;
  localparam logic [11:0] APB_MODE_VIEW = 12'h00c;
  localparam int IRQ_N = 3;
  localparam int IRQ_WAKE = 0;
  localparam int IRQ_SLEEP_ENTRY = 1;
  localparam int IRQ_PORT_WRITE = 2;

  //============================================================================
  // types
  typedef enum logic [1:0] {
    WK_IDLE = 2'b00,
    WK_WAKE = 2'b01,
    WK_TAG = 2'b10
  } ogrd_wake_t;

  typedef struct packed {
    logic sel;
    logic wr;
    logic [4:0] idx;
    logic [31:0] wdata;
  } ogrd_tp_req_t;

  typedef struct packed {
    logic sleeping;
    logic debug_mode;
    logic monitor;
    logic [2:0] priv;
    logic debug_mask_flag;
  } ogrd_cpu_mode_t;

endpackage : ogrd_pkg

// ### sim/ogrd_checker.sv
`timescale 1ns/1ps
module ogrd_checker (
  // clock and reset
  input wire logic sys_clk,
  input wire logic reset_n,
  // cpu side
  input wire ogrd_pkg::ogrd_cpu_mode_t cpu_mode,
  input wire logic cpu_dr_valid,
  input wire logic cpu_dr_wr,
  input wire logic [31:0] cpu_dr_rdata,
  input wire logic wake_req,
  input wire logic debug_exc_tag,
  input wire logic prog_trace_on,
  input wire logic data_trace_on,
  input wire logic mem_trace_on,
  input wire logic bkpt_allow,
  input wire logic watch_allow,
  // apb
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  input wire logic pslverr
);
  import ogrd_pkg::*;
  //=====
  // one domain, so one clock and one disable
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!reset_n);
  trace_off_dbg_a: assert property (cpu_mode.debug_mode |=>
    !(prog_trace_on | data_trace_on | mem_trace_on)) else $error("trace in debug");
  bkpt_gate_a: assert property (cpu_mode.debug_mode && !(cpu_mode.monitor &&
    !cpu_mode.debug_mask_flag) |=> !bkpt_allow) else $error("breakpoint not gated");
  watch_gate_a: assert property (cpu_mode.debug_mode |=>
    watch_allow == $past(cpu_mode.monitor)) else $error("watchpoint gate wrong");
  wake_hold_a: assert property (wake_req && cpu_mode.sleeping |=> wake_req)
    else $error("wake dropped early");
  tag_start_a: assert property (wake_req && !cpu_mode.sleeping |-> ##[1:2] debug_exc_tag)
    else $error("no debug tag");
  tag_hold_a: assert property (debug_exc_tag && !cpu_mode.debug_mode |=> debug_exc_tag)
    else $error("tag dropped");
  rdata_keep_a: assert property (!(cpu_dr_valid && !cpu_dr_wr && cpu_mode.priv != 3'h0)
    |=> $stable(cpu_dr_rdata)) else $error("read data moved");
  apb_wait_a: assert property (psel && penable && !pready |=> pready)
    else $error("apb answer late");
  apb_err_a: assert property (pslverr |-> pready && psel && penable)
    else $error("stray error");
  // main scenarios reached
  cover property (wake_req && !cpu_mode.sleeping);
  cover property (pslverr);
  cover property (cpu_dr_valid && cpu_dr_wr && cpu_mode.priv == 3'h0);
endmodule : ogrd_checker

bind ogrd_top ogrd_checker ogrd_checker_i (.sys_clk(sys_clk), .reset_n(reset_n),
  .cpu_mode(cpu_mode), .cpu_dr_valid(cpu_dr_valid), .cpu_dr_wr(cpu_dr_wr),
  .cpu_dr_rdata(cpu_dr_rdata), .wake_req(wake_req), .debug_exc_tag(debug_exc_tag),
  .prog_trace_on(prog_trace_on), .data_trace_on(data_trace_on),
  .mem_trace_on(mem_trace_on), .bkpt_allow(bkpt_allow), .watch_allow(watch_allow),
  .psel(psel), .penable(penable), .pready(pready), .pslverr(pslverr));

// ### sim/ogrd_dbg_model.sv
`timescale 1ns/1ps
module ogrd_dbg_model (
  // test port pins
  output logic tp_tck,
  output ogrd_pkg::ogrd_tp_req_t tp_req,
  input wire logic [31:0] tp_rdata
);
  import ogrd_pkg::*;
  // clock stands low between frames
  initial
  begin
    tp_tck = 1'b0;
    tp_req = '{sel: 1'b0, wr: 1'b0, idx: 5'h1f, wdata: 32'h5a5a5a5a};
  end
  // one access per rising edge, any index reachable
  // runtime writes outside the permitted table are the debugger's fault
  task automatic xfer(input logic w, input logic [4:0] i, input logic [31:0] d,
    output logic [31:0] q);
    #7;
    tp_req = '{sel: 1'b1, wr: w, idx: i, wdata: d};
    #80 tp_tck = 1'b1;
    #80 tp_tck = 1'b0;
    #80 q = tp_rdata;
    // released lines flip so a stale word never looks valid
    tp_req = '{sel: 1'b0, wr: ~w, idx: ~i, wdata: ~d};
  endtask : xfer
endmodule : ogrd_dbg_model

// ### sim/ogrd_top_test.sv
`timescale 1ns/1ps
module ogrd_top_test;
  import ogrd_pkg::*;
  //=====
  // design hookup
  logic sys_clk = 1'b0, reset_n = 1'b0, tp_tck, er;
  ogrd_tp_req_t tp_req;
  ogrd_cpu_mode_t cpu_mode = '0;
  logic cpu_dr_valid = 1'b0, cpu_dr_wr = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [4:0] cpu_dr_idx = 5'h00;
  logic [11:0] paddr = 12'h000;
  logic [31:0] cpu_dr_wdata = 32'h0, pwdata = 32'h0, tp_rdata, cpu_dr_rdata, prdata, rd;
  logic wake_req, debug_exc_tag, prog_trace_on, data_trace_on, mem_trace_on;
  logic bkpt_allow, watch_allow, pready, pslverr, irq;
  logic [31:0] ref_r [0:21]; // reference copy of the debug registers
  int n_fail = 0, n_checks = 0, seed = 17, cycles = 0;
  always #10 sys_clk = ~sys_clk;
  ogrd_top ogrd_top_i (.sys_clk(sys_clk), .reset_n(reset_n), .tp_tck(tp_tck),
    .tp_req(tp_req), .tp_rdata(tp_rdata), .cpu_dr_valid(cpu_dr_valid),
    .cpu_dr_wr(cpu_dr_wr), .cpu_dr_idx(cpu_dr_idx), .cpu_dr_wdata(cpu_dr_wdata),
    .cpu_mode(cpu_mode), .cpu_dr_rdata(cpu_dr_rdata), .wake_req(wake_req),
    .debug_exc_tag(debug_exc_tag), .prog_trace_on(prog_trace_on),
    .data_trace_on(data_trace_on), .mem_trace_on(mem_trace_on), .bkpt_allow(bkpt_allow),
    .watch_allow(watch_allow), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .irq(irq));
  ogrd_dbg_model ogrd_dbg_model_i (.tp_tck(tp_tck), .tp_req(tp_req), .tp_rdata(tp_rdata));
  //=====
  // shared tasks
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_checks = n_checks + 1;
    if (got !== exp)
    begin
      n_fail = n_fail + 1;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check
  task automatic stop_test();
    $display("checks=%0d fails=%0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : stop_test
  // hang guard, far above the expected run
  always @(posedge sys_clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 40000)
    begin
      n_fail = n_fail + 1;
      stop_test();
    end
  end
  // apb transfer: request held until pready is seen
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge sys_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    do @(posedge sys_clk); while (pready !== 1'b1 && ++k < 20);
    if (k >= 20)
      n_fail = n_fail + 1;
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    pwdata <= ~d;
  endtask : apb
  // one-cycle register move from the cpu
  task automatic cpu(input logic w, input logic [4:0] i, input logic [31:0] d);
    @(posedge sys_clk);
    cpu_dr_valid <= 1'b1;
    cpu_dr_wr <= w;
    cpu_dr_idx <= i;
    cpu_dr_wdata <= d;
    @(posedge sys_clk);
    cpu_dr_valid <= 1'b0;
    cpu_dr_wdata <= ~d;
    @(posedge sys_clk);
  endtask : cpu
  // bits a writer may change at this moment
  function automatic logic [31:0] wmask(input int i, input bit c);
    logic bp, bd, sd;
    bp = ref_r[10][3:0] != 4'h0;
    bd = ref_r[11][3:0] != 4'h0;
    sd = c && cpu_mode.debug_mask_flag;
    if (c && cpu_mode.priv == 3'h0) return '0;
    if (c && ref_r[0][DC_ORP_LSB + cpu_mode.priv - 1]) return (i == 15 || i == 20) ? '1 : '0;
    if ((!c && !ref_r[0][DC_EN_BIT]) || (cpu_mode.debug_mode && !cpu_mode.monitor)) return '1;
    case (i)
      1, 2, 3: return c ? '0 : '1;
      5: return c ? '1 : 32'h3;
      6, 8: return (c || !ref_r[5][0]) ? '1 : '0;
      7, 9: return (c || !ref_r[5][1]) ? '1 : '0;
      10, 11: return c ? (sd ? '1 : '0) : 32'hf;
      12: return (sd || !bp) ? '1 : '0;
      13, 14: return (sd || !bd) ? '1 : '0;
      17: return (sd || !(bp || bd)) ? '1 : '0;
      16, 18, 19: return '0;
      default: return '1;
    endcase
  endfunction : wmask
  // random write to indices 0 to 21, then read back
  task automatic round(input bit c, input bit en);
    logic [31:0] d, m, q;
    for (int i = 0; i < 22; i++)
    begin
      d = $random(seed);
      if (i == 0)
        d[1:0] = {en, 1'b0};
      m = wmask(i, c);
      if (c)
        cpu(1'b1, 5'(i), d);
      else
        ogrd_dbg_model_i.xfer(1'b1, 5'(i), d, q);
      ref_r[i] = (ref_r[i] & ~m) | (d & m);
      ogrd_dbg_model_i.xfer(1'b0, 5'(i), 32'h0, q);
      check(q, ref_r[i]);
      if (c && cpu_mode.priv != 3'h0)
      begin
        cpu(1'b0, 5'(i), 32'h0);
        check(cpu_dr_rdata, ref_r[i]);
      end
    end
  endtask : round
  //=====
  // main sequence
  initial
  begin
    for (int i = 0; i < 22; i++)
      ref_r[i] = 32'h0;
    repeat (3) @(posedge sys_clk);
    reset_n <= 1'b1;
    repeat (2) @(posedge sys_clk);
    apb(1'b0, 12'h010, 32'h0);
    check(er, 1'b1);
    check(rd, 32'h0);
    apb(1'b1, APB_IRQ_ENABLE, 32'h7);
    apb(1'b0, APB_IRQ_ENABLE, 32'h0);
    check(rd, 32'h7);
    for (int r = 0; r < 9; r++)
    begin
      @(posedge sys_clk);
      cpu_mode.debug_mode <= r > 2;
      cpu_mode.monitor <= r != 4 && r != 8;
      cpu_mode.priv <= (r == 7) ? 3'h0 : 3'({$random(seed)} % 7 + 1);
      cpu_mode.debug_mask_flag <= 1'($random(seed));
      @(posedge sys_clk);
      round(r > 4, r != 0);
      check({prog_trace_on, data_trace_on, mem_trace_on},
        (cpu_mode.debug_mode || !ref_r[0][1]) ? 3'h0 :
        {ref_r[0][9], ref_r[0][10] && (|ref_r[5][1:0]), ref_r[0][11]});
      check({bkpt_allow, watch_allow}, {!cpu_mode.debug_mode || (cpu_mode.monitor &&
        !cpu_mode.debug_mask_flag), !cpu_mode.debug_mode || cpu_mode.monitor});
      if (r == 1)
      begin
        apb(1'b0, APB_IRQ_STATUS, 32'h0);
        check(irq, 1'b1);
        check(rd, 32'h4);
        apb(1'b1, APB_IRQ_ENABLE, 32'h0);
        repeat (2) @(posedge sys_clk);
        check(irq, 1'b0);
        apb(1'b1, APB_IRQ_CLEAR, 32'h7);
        apb(1'b1, APB_IRQ_ENABLE, 32'h7);
        apb(1'b0, APB_IRQ_STATUS, 32'h0);
        repeat (2) @(posedge sys_clk);
        check(irq, 1'b0);
        check(rd, 32'h0);
      end
    end
    // wake from sleep on a debug request
    cpu_mode <= '{sleeping: 1'b1, debug_mode: 1'b0, monitor: 1'b0, priv: 3'h1, debug_mask_flag: 1'b0};
    ogrd_dbg_model_i.xfer(1'b1, IDX_DEBUG_CONTROL, 32'h3, rd);
    for (int k = 0; k < 50 && wake_req !== 1'b1; k++) @(posedge sys_clk);
    check(wake_req, 1'b1);
    cpu_mode.sleeping <= 1'b0;
    for (int k = 0; k < 50 && debug_exc_tag !== 1'b1; k++) @(posedge sys_clk);
    check({wake_req, debug_exc_tag}, 2'b01);
    cpu_mode.debug_mode <= 1'b1;
    repeat (3) @(posedge sys_clk);
    check(debug_exc_tag, 1'b0);
    ogrd_dbg_model_i.xfer(1'b0, IDX_DEV_STATUS, 32'h0, rd);
    check(rd[DS_STOP_BIT], 1'b1);
    ogrd_dbg_model_i.xfer(1'b0, IDX_DEBUG_CONTROL, 32'h0, rd);
    check(rd, 32'h2);
    apb(1'b0, APB_IRQ_STATUS, 32'h0);
    check(irq, 1'b1);
    check(rd, 32'h7);
    cpu_mode.debug_mode <= 1'b0;
    ogrd_dbg_model_i.xfer(1'b0, IDX_DEV_STATUS, 32'h0, rd);
    check(rd[DS_STOP_BIT], 1'b0);
    stop_test();
  end
endmodule : ogrd_top_test
